// >>> include/atpwm_pkg.sv
// constants, register map and carrier types of the autoreload pwm timer
package atpwm_pkg;
  localparam logic [7:0] ADDR_TIMER_CTRL_STATUS = 8'h0D;
  localparam logic [7:0] ADDR_COUNTER_HIGH = 8'h0E;
  localparam logic [7:0] ADDR_COUNTER_LOW = 8'h0F;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h10;
  localparam logic [7:0] ADDR_RELOAD_LOW = 8'h11;
  localparam logic [7:0] ADDR_OUTPUT_CTRL = 8'h12;
  localparam logic [7:0] ADDR_OUTPUT_CTRL_STATUS = 8'h13;
  localparam logic [7:0] ADDR_DUTY_HIGH = 8'h17;
  localparam logic [7:0] ADDR_DUTY_LOW = 8'h18;
  // field positions
  localparam int SRC_HI = 4;
  localparam int SRC_LO = 3;
  localparam int OVF_BIT = 2;
  localparam int OVERFLOW_IRQ_ENABLE_BIT = 1;
  localparam int COMPARE_IRQ_ENABLE_BIT = 0;
  localparam int POL_BIT = 1;
  localparam int CMPF_BIT = 0;
  localparam int OE_BIT = 0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [11:0] COUNT_MAX = 12'hFFF;
  localparam logic [11:0] COUNT_ZERO = 12'h000;
  localparam logic [11:0] COUNT_ONE = 12'h001;
  localparam logic [3:0] HIGH_ZERO = 4'h0;
  // counter source select encodings
  typedef enum logic [1:0] {
    SRC_OFF = 2'b00,
    SRC_TIMEBASE = 2'b01,
    SRC_CPU = 2'b10,
    SRC_RSVD = 2'b11
  } atpwm_src_t;
  // register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } atpwm_bus_t;
endpackage

// >>> rtl/atpwm_tick_sel.sv
// counter tick selection from the chosen clock source
`timescale 1ns/1ns
module atpwm_tick_sel
  import atpwm_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [1:0] srcSel,
  input wire logic timebaseTick,
  output logic countTick
);
  // registered tick; reserved and off selections give no tick
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      countTick <= 1'b0;
    end else begin
      case (srcSel)
        SRC_TIMEBASE: countTick <= timebaseTick;
        SRC_CPU: countTick <= 1'b1;
        SRC_OFF: countTick <= 1'b0;
        default: countTick <= 1'b0;
      endcase
    end
  end
endmodule

// >>> rtl/atpwm_timer.sv
// 12-bit autoreload timer with one pwm output and output compare
//
// The strobed register port was decided locally.
`timescale 1ns/1ns
// Summary of operation
// - source select: 00 off, 01 timebase tick, 10 cpu clock, 11 reserved
// - overflow flag sets when the counter passes from FFF to reload value
// - reading timer control/status clears overflow flag; writes do not
// - cleared overflow flag stays high one more counter tick
// - overflow irq enable gates overflow request; reset clears it
// - compare irq enable gates compare request; reset clears it
// - 12-bit counter counts each tick, resets to zero, read as two bytes
// - on overflow the counter reloads from the reload register
// - reload register is writable and sets the output period
// - output enable 1: duty sets pwm; 0: duty is compare target
// - polarity bit 1 inverts the modulated output; reset clears it
// - compare flag sets on counter equal duty; output status read clears it
// - output enable 0 releases the pin; 1 drives the waveform
// - overflow loads active duty and drives high; match drives low
// - compare mode duty acts at once; high write suspends compare until low
// - compare only works for nonzero duty values
module atpwm_timer
  import atpwm_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [7:0] busAddr,
  input wire logic [7:0] busWdata,
  input wire logic busWr,
  input wire logic busRd,
  output logic [7:0] busRdata,
  input wire logic timebaseTick,
  output logic pwmOut,
  output logic pwmOutEn,
  output logic overflowIrq,
  output logic compareIrq
);
  atpwm_bus_t bus;
  logic [1:0] srcSel;
  logic overflowFlag;
  logic ovfClearPending;
  logic overflowIrqEnable;
  logic compareIrqEnable;
  logic [11:0] countValue;
  logic [11:0] reloadValue;
  logic [11:0] dutyValue;
  logic [11:0] dutyShadow;
  logic compareLocked;
  logic outputEnable;
  logic outputPolarity;
  logic compareFlag;
  logic pwmLevel;
  logic countTick;
  logic overflowEvent;
  logic [11:0] compareTarget;
  logic compareHit;
  logic [7:0] next_rdata;

  assign bus = '{addr: busAddr, wdata: busWdata, wr: busWr, rd: busRd};

  function automatic logic hit(input atpwm_bus_t b, input logic [7:0] a, input logic isWr);
    hit = (b.addr == a) && (isWr ? b.wr : b.rd);
  endfunction

  atpwm_tick_sel u_tick (
    .core_clk(core_clk),
    .rstn(rstn),
    .srcSel(srcSel),
    .timebaseTick(timebaseTick),
    .countTick(countTick)
  );

  // overflow and compare decode
  assign overflowEvent = countTick && (countValue == COUNT_MAX);
  assign compareTarget = outputEnable ? dutyShadow : dutyValue;
  assign compareHit = countTick && !compareLocked && (compareTarget != COUNT_ZERO)
    && (countValue == compareTarget);

  // control/status fields
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      srcSel <= 2'b00;
      overflowIrqEnable <= 1'b0;
      compareIrqEnable <= 1'b0;
    end else if (hit(bus, ADDR_TIMER_CTRL_STATUS, 1'b1)) begin
      srcSel <= bus.wdata[SRC_HI:SRC_LO];
      overflowIrqEnable <= bus.wdata[OVERFLOW_IRQ_ENABLE_BIT];
      compareIrqEnable <= bus.wdata[COMPARE_IRQ_ENABLE_BIT];
    end
  end

  // counter with autoreload
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      countValue <= COUNT_ZERO;
    end else if (overflowEvent) begin
      countValue <= reloadValue;
    end else if (countTick) begin
      countValue <= countValue + COUNT_ONE;
    end
  end

  // overflow flag: set wins; a read arms a clear taken one tick later
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      overflowFlag <= 1'b0;
      ovfClearPending <= 1'b0;
    end else begin
      if (overflowEvent) begin
        overflowFlag <= 1'b1;
        ovfClearPending <= 1'b0;
      end else if (ovfClearPending && countTick) begin
        overflowFlag <= 1'b0;
        ovfClearPending <= 1'b0;
      end else if (hit(bus, ADDR_TIMER_CTRL_STATUS, 1'b0) && overflowFlag) begin
        ovfClearPending <= 1'b1;
      end
    end
  end

  // reload register bytes
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      reloadValue <= COUNT_ZERO;
    end else begin
      if (hit(bus, ADDR_RELOAD_HIGH, 1'b1)) begin
        reloadValue[11:8] <= bus.wdata[3:0];
      end
      if (hit(bus, ADDR_RELOAD_LOW, 1'b1)) begin
        reloadValue[7:0] <= bus.wdata;
      end
    end
  end

  // duty preload, lock between high and low byte writes
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      dutyValue <= COUNT_ZERO;
      compareLocked <= 1'b0;
    end else begin
      if (hit(bus, ADDR_DUTY_HIGH, 1'b1)) begin
        dutyValue[11:8] <= bus.wdata[3:0];
        compareLocked <= 1'b1;
      end
      if (hit(bus, ADDR_DUTY_LOW, 1'b1)) begin
        dutyValue[7:0] <= bus.wdata;
        compareLocked <= 1'b0;
      end
    end
  end

  // active duty shadow loaded at each overflow
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      dutyShadow <= COUNT_ZERO;
    end else if (overflowEvent) begin
      dutyShadow <= dutyValue;
    end
  end

  // output control and polarity
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      outputEnable <= 1'b0;
      outputPolarity <= 1'b0;
    end else begin
      if (hit(bus, ADDR_OUTPUT_CTRL, 1'b1)) begin
        outputEnable <= bus.wdata[OE_BIT];
      end
      if (hit(bus, ADDR_OUTPUT_CTRL_STATUS, 1'b1)) begin
        outputPolarity <= bus.wdata[POL_BIT];
      end
    end
  end

  // compare flag: set wins over read clear
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      compareFlag <= 1'b0;
    end else if (compareHit) begin
      compareFlag <= 1'b1;
    end else if (hit(bus, ADDR_OUTPUT_CTRL_STATUS, 1'b0)) begin
      compareFlag <= 1'b0;
    end
  end

  // raw pwm level: high at overflow, low on match
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pwmLevel <= 1'b0;
    end else if (overflowEvent) begin
      pwmLevel <= 1'b1;
    end else if (compareHit && outputEnable) begin
      pwmLevel <= 1'b0;
    end
  end

  // pin drive and interrupt outputs
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pwmOut <= 1'b0;
      pwmOutEn <= 1'b0;
      overflowIrq <= 1'b0;
      compareIrq <= 1'b0;
    end else begin
      pwmOut <= outputEnable & (pwmLevel ^ outputPolarity);
      pwmOutEn <= outputEnable;
      overflowIrq <= overflowFlag & overflowIrqEnable;
      compareIrq <= compareFlag & compareIrqEnable;
    end
  end

  // read mux, reserved bits zero
  always_comb begin
    next_rdata = BYTE_ZERO;
    case (bus.addr)
      ADDR_TIMER_CTRL_STATUS: next_rdata = {3'b000, srcSel, overflowFlag, overflowIrqEnable, compareIrqEnable};
      ADDR_COUNTER_HIGH: next_rdata = {HIGH_ZERO, countValue[11:8]};
      ADDR_COUNTER_LOW: next_rdata = countValue[7:0];
      ADDR_RELOAD_HIGH: next_rdata = {HIGH_ZERO, reloadValue[11:8]};
      ADDR_RELOAD_LOW: next_rdata = reloadValue[7:0];
      ADDR_OUTPUT_CTRL: next_rdata = {7'b000_0000, outputEnable};
      ADDR_OUTPUT_CTRL_STATUS: next_rdata = {6'b00_0000, outputPolarity, compareFlag};
      ADDR_DUTY_HIGH: next_rdata = {HIGH_ZERO, dutyValue[11:8]};
      ADDR_DUTY_LOW: next_rdata = dutyValue[7:0];
      default: next_rdata = BYTE_ZERO;
    endcase
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      busRdata <= BYTE_ZERO;
    end else begin
      busRdata <= bus.rd ? next_rdata : BYTE_ZERO;
    end
  end

  sequence s_ovf_read;
    overflowFlag && !ovfClearPending && hit(bus, ADDR_TIMER_CTRL_STATUS, 1'b0) && !overflowEvent;
  endsequence

  property p_ovf_set;
    @(posedge core_clk) disable iff (!rstn) overflowEvent |=> overflowFlag && countValue == $past(reloadValue);
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow did not set flag or reload");

  property p_ovf_hold;
    @(posedge core_clk) disable iff (!rstn) s_ovf_read |=> overflowFlag;
  endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag cleared too early");

  property p_ovf_write;
    @(posedge core_clk) disable iff (!rstn)
      overflowFlag && !ovfClearPending && !busRd |=> overflowFlag;
  endproperty
  a_ovf_write: assert property (p_ovf_write) else $error("overflow flag lost without read");

  property p_count_inc;
    @(posedge core_clk) disable iff (!rstn)
      countTick && !overflowEvent |=> countValue == $past(countValue) + COUNT_ONE;
  endproperty
  a_count_inc: assert property (p_count_inc) else $error("counter did not increment");

  property p_stopped;
    @(posedge core_clk) disable iff (!rstn) (srcSel == SRC_OFF || srcSel == SRC_RSVD) [*2] |=> $stable(countValue);
  endproperty
  a_stopped: assert property (p_stopped) else $error("counter moved while stopped");

  property p_cmp_zero;
    @(posedge core_clk) disable iff (!rstn) compareTarget == COUNT_ZERO |=> !$rose(compareFlag);
  endproperty
  a_cmp_zero: assert property (p_cmp_zero) else $error("compare flag set on zero duty");

  property p_cmp_flag;
    @(posedge core_clk) disable iff (!rstn) compareHit |=> compareFlag;
  endproperty
  a_cmp_flag: assert property (p_cmp_flag) else $error("compare flag not set");

  property p_irq;
    @(posedge core_clk) disable iff (!rstn)
      1'b1 |=> overflowIrq == ($past(overflowFlag) && $past(overflowIrqEnable));
  endproperty
  a_irq: assert property (p_irq) else $error("overflow request mismatch");

  property p_pin_release;
    @(posedge core_clk) disable iff (!rstn) !outputEnable |=> !pwmOutEn && !pwmOut;
  endproperty
  a_pin_release: assert property (p_pin_release) else $error("pin driven while disabled");

  property p_pwm_high;
    @(posedge core_clk) disable iff (!rstn)
      overflowEvent && outputEnable ##1 outputEnable |=> pwmOut == !$past(outputPolarity);
  endproperty
  a_pwm_high: assert property (p_pwm_high) else $error("pwm not set at overflow");

  // compare, output and register checks
  property p_cmp_irq;
    @(posedge core_clk) disable iff (!rstn)
      1'b1 |=> compareIrq == ($past(compareFlag) && $past(compareIrqEnable));
  endproperty
  a_cmp_irq: assert property (p_cmp_irq) else $error("compare request mismatch");

  property p_cmp_lock;
    @(posedge core_clk) disable iff (!rstn) compareLocked |=> !$rose(compareFlag);
  endproperty
  a_cmp_lock: assert property (p_cmp_lock) else $error("compare flag set while locked");

  property p_lock_set;
    @(posedge core_clk) disable iff (!rstn) hit(bus, ADDR_DUTY_HIGH, 1'b1) |=> compareLocked;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("duty high write did not lock compare");

  property p_cmp_clear;
    @(posedge core_clk) disable iff (!rstn) hit(bus, ADDR_OUTPUT_CTRL_STATUS, 1'b0) && !compareHit |=> !compareFlag;
  endproperty
  a_cmp_clear: assert property (p_cmp_clear) else $error("compare flag survived status read");

  property p_shadow_load;
    @(posedge core_clk) disable iff (!rstn) overflowEvent |=> dutyShadow == $past(dutyValue);
  endproperty
  a_shadow_load: assert property (p_shadow_load) else $error("active duty not loaded at overflow");

  sequence s_pwm_match;
    compareHit && outputEnable && !overflowEvent ##1 outputEnable;
  endsequence

  property p_pwm_low;
    @(posedge core_clk) disable iff (!rstn) s_pwm_match |=> pwmOut == $past(outputPolarity);
  endproperty
  a_pwm_low: assert property (p_pwm_low) else $error("pwm not cleared on match");

  property p_oe_follow;
    @(posedge core_clk) disable iff (!rstn) 1'b1 |=> pwmOutEn == $past(outputEnable);
  endproperty
  a_oe_follow: assert property (p_oe_follow) else $error("pin enable does not follow output enable");

  property p_reserved_read;
    @(posedge core_clk) disable iff (!rstn)
      bus.rd && (bus.addr == ADDR_COUNTER_HIGH || bus.addr == ADDR_RELOAD_HIGH || bus.addr == ADDR_DUTY_HIGH)
      |=> busRdata[7:4] == HIGH_ZERO;
  endproperty
  a_reserved_read: assert property (p_reserved_read) else $error("reserved high bits read nonzero");

  property p_reload_write;
    @(posedge core_clk) disable iff (!rstn) hit(bus, ADDR_RELOAD_LOW, 1'b1) |=> reloadValue[7:0] == $past(busWdata);
  endproperty
  a_reload_write: assert property (p_reload_write) else $error("reload low byte not written");
endmodule

// >>> dv/autoreload_timer_pwm_tb.sv
// self-checking bench for the autoreload pwm timer
`timescale 1ns/1ns
module autoreload_timer_pwm_tb;
  import atpwm_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] busAddr = BYTE_ZERO;
  logic [7:0] busWdata = BYTE_ZERO;
  logic busWr = 1'b0;
  logic busRd = 1'b0;
  logic [7:0] busRdata;
  logic timebaseTick = 1'b0;
  logic pwmOut;
  logic pwmOutEn;
  logic overflowIrq;
  logic compareIrq;
  int miscompares = 0;
  int numChecks = 0;
  logic [7:0] rv;
  logic [7:0] rv2;

  atpwm_timer i_dut (
    .core_clk(core_clk),
    .rstn(rstn),
    .busAddr(busAddr),
    .busWdata(busWdata),
    .busWr(busWr),
    .busRd(busRd),
    .busRdata(busRdata),
    .timebaseTick(timebaseTick),
    .pwmOut(pwmOut),
    .pwmOutEn(pwmOutEn),
    .overflowIrq(overflowIrq),
    .compareIrq(compareIrq)
  );

  // 100 ns clock
  initial begin
    forever #50 core_clk = ~core_clk;
  end

  // compare and count
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    numChecks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    busAddr <= a;
    busWdata <= d;
    busWr <= 1'b1;
    @(posedge core_clk);
    busWr <= 1'b0;
  endtask

  // one-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    busAddr <= a;
    busRd <= 1'b1;
    @(posedge core_clk);
    busRd <= 1'b0;
    @(negedge core_clk);
    d = busRdata;
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    rd(a, rv);
    chk(what, {4'h0, exp}, {4'h0, rv});
  endtask

  // one timebase tick pulse
  task automatic tbTick;
    @(posedge core_clk);
    timebaseTick <= 1'b1;
    @(posedge core_clk);
    timebaseTick <= 1'b0;
  endtask

  // cycles of pwmOut high within a window
  task automatic countHigh(input int span, output int n);
    n = 0;
    repeat (span) begin
      @(negedge core_clk);
      if (pwmOut === 1'b1) n++;
    end
  endtask

  task automatic testResetValues;
    logic [7:0] addrs [10];
    addrs = '{ADDR_TIMER_CTRL_STATUS, ADDR_COUNTER_HIGH, ADDR_COUNTER_LOW, ADDR_RELOAD_HIGH, ADDR_RELOAD_LOW,
      ADDR_OUTPUT_CTRL, ADDR_OUTPUT_CTRL_STATUS, ADDR_DUTY_HIGH, ADDR_DUTY_LOW, 8'h14};
    foreach (addrs[i]) rdchk("reset value", addrs[i], BYTE_ZERO);
    chk("pin enable at reset", 12'h000, {11'h000, pwmOutEn});
    wr(8'h14, 8'hAB);
    rdchk("unmapped", 8'h14, BYTE_ZERO);
    wr(ADDR_COUNTER_LOW, 8'h55);
    rdchk("counter read only", ADDR_COUNTER_LOW, BYTE_ZERO);
    wr(ADDR_RELOAD_HIGH, 8'h0F);
    wr(ADDR_RELOAD_LOW, 8'h00);
    rdchk("reload high", ADDR_RELOAD_HIGH, 8'h0F);
    rdchk("reload low", ADDR_RELOAD_LOW, BYTE_ZERO);
    $display("test reset values done");
  endtask

  task automatic testOverflow;
    int n;
    wr(ADDR_TIMER_CTRL_STATUS, 8'h10);
    repeat (4300) @(posedge core_clk);
    chk("ovf irq masked", 12'h000, {11'h000, overflowIrq});
    rdchk("ovf flag set", ADDR_TIMER_CTRL_STATUS, 8'h14);
    rdchk("ovf flag cleared", ADDR_TIMER_CTRL_STATUS, 8'h10);
    rd(ADDR_COUNTER_LOW, rv2);
    rdchk("counter high after reload", ADDR_COUNTER_HIGH, 8'h0F);
    wr(ADDR_TIMER_CTRL_STATUS, 8'h12);
    n = 0;
    while (overflowIrq !== 1'b1 && n < 300) begin
      @(posedge core_clk);
      n++;
    end
    chk("ovf irq raised", 12'h001, {11'h000, overflowIrq});
    rdchk("ovf flag again", ADDR_TIMER_CTRL_STATUS, 8'h16);
    rdchk("ovf flag gone", ADDR_TIMER_CTRL_STATUS, 8'h12);
    wr(ADDR_TIMER_CTRL_STATUS, 8'h16);
    rdchk("ovf flag not written", ADDR_TIMER_CTRL_STATUS, 8'h12);
    $display("test overflow done");
  endtask

  task automatic testSlowClear;
    int n;
    wr(ADDR_TIMER_CTRL_STATUS, 8'h0A);
    n = 0;
    while (overflowIrq !== 1'b1 && n < 600) begin
      tbTick();
      n++;
    end
    repeat (3) @(posedge core_clk);
    rdchk("slow ovf set", ADDR_TIMER_CTRL_STATUS, 8'h0E);
    rdchk("ovf held until tick", ADDR_TIMER_CTRL_STATUS, 8'h0E);
    tbTick();
    repeat (3) @(posedge core_clk);
    rdchk("ovf falls after tick", ADDR_TIMER_CTRL_STATUS, 8'h0A);
    chk("ovf irq dropped", 12'h000, {11'h000, overflowIrq});
    for (int s = 0; s < 4; s += 3) begin
      wr(ADDR_TIMER_CTRL_STATUS, 8'(s << 3));
      rd(ADDR_COUNTER_LOW, rv2);
      repeat (6) @(posedge core_clk);
      rdchk("stopped counter", ADDR_COUNTER_LOW, rv2);
    end
    $display("test slow clear done");
  endtask

  task automatic testPwm;
    int n;
    wr(ADDR_TIMER_CTRL_STATUS, 8'h10);
    wr(ADDR_DUTY_HIGH, 8'h0F);
    wr(ADDR_DUTY_LOW, 8'hC0);
    wr(ADDR_OUTPUT_CTRL, 8'h01);
    repeat (300) @(posedge core_clk);
    countHigh(512, n);
    chk("pwm high cycles", 12'd386, 12'(n));
    chk("pin driven", 12'h001, {11'h000, pwmOutEn});
    wr(ADDR_OUTPUT_CTRL_STATUS, 8'h02);
    repeat (4) @(posedge core_clk);
    countHigh(512, n);
    chk("inverted high cycles", 12'd126, 12'(n));
    wr(ADDR_OUTPUT_CTRL_STATUS, 8'h00);
    wr(ADDR_OUTPUT_CTRL, 8'h00);
    repeat (3) @(posedge core_clk);
    chk("pin released", 12'h000, {10'h000, pwmOutEn, pwmOut});
    $display("test pwm done");
  endtask

  task automatic testCompare;
    int n;
    rd(ADDR_OUTPUT_CTRL_STATUS, rv2);
    repeat (300) @(posedge core_clk);
    chk("cmp irq masked", 12'h000, {11'h000, compareIrq});
    rdchk("cmp flag set", ADDR_OUTPUT_CTRL_STATUS, 8'h01);
    rdchk("cmp flag cleared", ADDR_OUTPUT_CTRL_STATUS, 8'h00);
    wr(ADDR_TIMER_CTRL_STATUS, 8'h11);
    n = 0;
    while (compareIrq !== 1'b1 && n < 300) begin
      @(posedge core_clk);
      n++;
    end
    chk("cmp irq raised", 12'h001, {11'h000, compareIrq});
    wr(ADDR_DUTY_HIGH, 8'h0F);
    rd(ADDR_OUTPUT_CTRL_STATUS, rv2);
    repeat (300) @(posedge core_clk);
    rdchk("compare locked", ADDR_OUTPUT_CTRL_STATUS, 8'h00);
    wr(ADDR_DUTY_LOW, 8'h80);
    repeat (300) @(posedge core_clk);
    rdchk("compare unlocked", ADDR_OUTPUT_CTRL_STATUS, 8'h01);
    // reload zero so the counter wraps through zero with a zero duty
    wr(ADDR_RELOAD_HIGH, BYTE_ZERO);
    wr(ADDR_DUTY_HIGH, 8'h00);
    wr(ADDR_DUTY_LOW, 8'h00);
    rd(ADDR_OUTPUT_CTRL_STATUS, rv2);
    repeat (300) @(posedge core_clk);
    rdchk("zero duty no compare", ADDR_OUTPUT_CTRL_STATUS, 8'h00);
    $display("test compare done");
  endtask

  // counts, verdict and end of run
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // cut a hang short
  initial begin
    repeat (30000) @(posedge core_clk);
    miscompares++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    testResetValues();
    testOverflow();
    testSlowClear();
    testPwm();
    testCompare();
    tally_and_finish();
  end
endmodule
